// ### verilog/light_cmd_pkg.sv
// constants and carrier types shared by the light sensor command port
package light_cmd_pkg;

    // system clock rate and documented timings
    localparam int SYS_CLK_MHZ    = 40;
    localparam int H_MEAS_TIME_MS = 120;
    localparam int L_MEAS_TIME_MS = 16;
    localparam int RESET_LOW_NS   = 1000;
    localparam int RESET_LOW_CYCLES = (RESET_LOW_NS * SYS_CLK_MHZ + 999) / 1000;

    // measurement time setting: width, power-up value and field positions
    localparam int         TIME_SET_W      = 8;
    localparam logic [7:0] TIME_SET_RESET  = 8'h45;
    localparam int         TIME_HI_MSB     = 7;
    localparam int         TIME_HI_LSB     = 5;
    localparam int         TIME_LO_MSB     = 4;
    localparam int         TIME_LO_LSB     = 0;
    localparam logic [4:0] TIME_HI_PREFIX  = 5'h08;
    localparam logic [2:0] TIME_LO_PREFIX  = 3'h3;

    // cycles per unit of setting; a full window is setting times this
    localparam int H_UNIT_CYCLES =
        (H_MEAS_TIME_MS * 1000 * SYS_CLK_MHZ) / 69;
    localparam int L_UNIT_CYCLES =
        (L_MEAS_TIME_MS * 1000 * SYS_CLK_MHZ) / 69;
    localparam int UNIT_CNT_W    = 17;

    // opcodes
    localparam logic [7:0] OP_POWER_DOWN = 8'h00;
    localparam logic [7:0] OP_POWER_ON   = 8'h01;
    localparam logic [7:0] OP_DATA_CLEAR = 8'h07;
    localparam logic [7:0] OP_CONT_H     = 8'h10;
    localparam logic [7:0] OP_CONT_L     = 8'h13;
    localparam logic [7:0] OP_ONCE_H     = 8'h20;
    localparam logic [7:0] OP_ONCE_L     = 8'h23;

    // slave addresses picked by the address select pin
    localparam logic [6:0] SLAVE_ADDR_HIGH = 7'h5c;
    localparam logic [6:0] SLAVE_ADDR_LOW  = 7'h23;

    // one received opcode with its valid mark
    typedef struct packed {
        logic       pend;
        logic [7:0] op;
    } cmd_word_t;

    // serial engine states
    typedef enum logic [2:0] {
        L_IDLE, L_ADDR, L_ADDR_ACK, L_WR_BYTE, L_WR_ACK, L_RD_BYTE, L_RD_ACK, L_IGNORE
    } link_state_t;

endpackage

// ### verilog/sync_two_ff.sv
// two-stage level synchroniser, width set by parameter
`timescale 1ns/1ps
`default_nettype none
module sync_two_ff #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_ff;  // first stage, read only by the second

    // both stages clear to zero under reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            q       <= '0;
        end else begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end
endmodule
`default_nettype wire

// ### verilog/light_cmd_port.sv
// serial command port of the ambient light sensor: link engine and measurement control
// Summary of operation
// - one opcode per write, stop commits it
// - 8-bit time setting, power-up value 0x45
// - prefix 01000 loads setting bits 7:5
// - prefix 011 loads setting bits 4:0
// - window loss compensated by longer integration
// - doubled setting doubles result update time
// - new setting applied at next start opcode
// - reset pin clears registers asynchronously
// - power-down while reset pin is low
// - address 0x5c or 0x23 by select pin
// - read returns high byte then low byte
`timescale 1ns/1ps
`default_nettype none
module light_cmd_port #(
    parameter int H_UNIT = light_cmd_pkg::H_UNIT_CYCLES,
    parameter int L_UNIT = light_cmd_pkg::L_UNIT_CYCLES
) (
    input  wire logic        SYS_CLK,
    input  wire logic        RST,
    input  wire logic        LINK_RESET_N,
    input  wire logic        SCL,
    input  wire logic        SDA_IN,
    output logic             SDA_OUT,
    output logic             SDA_OE,
    input  wire logic        ADDR_SEL,
    input  wire logic [15:0] LIGHT_COUNT,
    output logic      [7:0]  MEAS_TIME,
    output logic             POWERED_ON,
    output logic             MEASURING,
    output logic             HIGH_RES
);
    // ---------------- link (SCL) domain ----------------
    logic                     start_tog_ff;  // flips on every start condition
    logic                     stop_tog_ff;   // flips on every stop condition
    logic                     start_seen_ff; // last start toggle taken by the engine
    light_cmd_pkg::link_state_t st_ff;       // serial engine state
    logic [6:0]               sh_ff;         // incoming bit shifter
    logic [2:0]               cnt_ff;        // bit position within a byte
    logic                     rw_ff;         // direction bit of the transfer
    logic [15:0]              rd_sh_ff;      // outgoing result shifter
    logic                     rd_low_ff;     // low byte is being sent
    light_cmd_pkg::cmd_word_t cmd_ff;        // opcode of the current write
    logic [15:0]              rd_word_ff;    // link-side copy of the result
    logic                     data_seen_ff;  // last result toggle taken
    logic [1:0]               link_sync;     // synchronised address select and toggle
    logic [6:0]               own_addr;      // address this port answers to
    logic                     start_new;     // unseen start pending

    // sys domain signals read by the link side
    logic [15:0]              data_ff;       // result register
    logic                     data_tog_ff;   // flips whenever the result changes

    // start: sda falls while scl high; scl is steady there by bus protocol
    always_ff @(negedge SDA_IN or negedge LINK_RESET_N) begin
        if (!LINK_RESET_N) begin
            start_tog_ff <= 1'b0;
        end else if (SCL) begin
            start_tog_ff <= ~start_tog_ff;
        end
    end

    // stop: sda rises while scl high; this event commits a write
    always_ff @(posedge SDA_IN or negedge LINK_RESET_N) begin
        if (!LINK_RESET_N) begin
            stop_tog_ff <= 1'b0;
        end else if (SCL) begin
            stop_tog_ff <= ~stop_tog_ff;
        end
    end

    // address select pin and result toggle into the link domain
    sync_two_ff #(.W(2)) u_link_sync (
        .clk   (SCL),
        .rst_n (LINK_RESET_N),
        .d     ({ADDR_SEL, data_tog_ff}),
        .q     (link_sync)
    );

    // select pin picks one of two addresses
    assign own_addr  = link_sync[1] ? light_cmd_pkg::SLAVE_ADDR_HIGH
                                    : light_cmd_pkg::SLAVE_ADDR_LOW;
    assign start_new = start_tog_ff != start_seen_ff;

    // take a fresh result copy when the sys side publishes one
    always_ff @(posedge SCL or negedge LINK_RESET_N) begin
        if (!LINK_RESET_N) begin
            rd_word_ff   <= 16'h0000;
            data_seen_ff <= 1'b0;
        end else if (link_sync[0] != data_seen_ff) begin
            rd_word_ff   <= data_ff;
            data_seen_ff <= link_sync[0];
        end
    end

    // serial engine: bits are sampled on the rising scl edge
    always_ff @(posedge SCL or negedge LINK_RESET_N) begin
        if (!LINK_RESET_N) begin
            st_ff         <= light_cmd_pkg::L_IDLE;
            start_seen_ff <= 1'b0;
            sh_ff         <= 7'h00;
            cnt_ff        <= 3'h0;
            rw_ff         <= 1'b0;
            rd_sh_ff      <= 16'h0000;
            rd_low_ff     <= 1'b0;
            cmd_ff        <= '0;
        end else if (start_new) begin
            // first address bit follows the start; any held opcode is dropped
            start_seen_ff <= start_tog_ff;
            st_ff         <= light_cmd_pkg::L_ADDR;
            sh_ff         <= {6'h00, SDA_IN};
            cnt_ff        <= 3'h1;
            cmd_ff.pend   <= 1'b0;
        end else begin
            unique case (st_ff)
                light_cmd_pkg::L_IDLE, light_cmd_pkg::L_IGNORE: begin
                    cnt_ff <= 3'h0;   // wait for the next start
                end
                light_cmd_pkg::L_ADDR: begin
                    sh_ff  <= {sh_ff[5:0], SDA_IN};
                    cnt_ff <= cnt_ff + 3'h1;
                    if (cnt_ff == 3'h7) begin
                        if (sh_ff == own_addr) begin
                            rw_ff <= SDA_IN;
                            st_ff <= light_cmd_pkg::L_ADDR_ACK;
                        end else begin
                            st_ff <= light_cmd_pkg::L_IGNORE;
                        end
                    end
                end
                light_cmd_pkg::L_ADDR_ACK: begin
                    cnt_ff <= 3'h0;
                    if (rw_ff) begin
                        rd_sh_ff  <= rd_word_ff;
                        rd_low_ff <= 1'b0;
                        st_ff     <= light_cmd_pkg::L_RD_BYTE;
                    end else begin
                        st_ff <= light_cmd_pkg::L_WR_BYTE;
                    end
                end
                light_cmd_pkg::L_WR_BYTE: begin
                    sh_ff  <= {sh_ff[5:0], SDA_IN};
                    cnt_ff <= cnt_ff + 3'h1;
                    if (cnt_ff == 3'h7) begin
                        // a second opcode in one transfer is not acknowledged
                        if (!cmd_ff.pend) begin
                            cmd_ff.op   <= {sh_ff, SDA_IN};
                            cmd_ff.pend <= 1'b1;
                            st_ff       <= light_cmd_pkg::L_WR_ACK;
                        end else begin
                            st_ff <= light_cmd_pkg::L_IGNORE;
                        end
                    end
                end
                light_cmd_pkg::L_WR_ACK: begin
                    cnt_ff <= 3'h0;
                    st_ff  <= light_cmd_pkg::L_WR_BYTE;
                end
                light_cmd_pkg::L_RD_BYTE: begin
                    rd_sh_ff <= {rd_sh_ff[14:0], 1'b0};
                    cnt_ff   <= cnt_ff + 3'h1;
                    if (cnt_ff == 3'h7) begin
                        st_ff <= light_cmd_pkg::L_RD_ACK;
                    end
                end
                light_cmd_pkg::L_RD_ACK: begin
                    cnt_ff <= 3'h0;
                    // ack after the high byte sends the low byte, else stop talking
                    if (!SDA_IN && !rd_low_ff) begin
                        rd_low_ff <= 1'b1;
                        st_ff     <= light_cmd_pkg::L_RD_BYTE;
                    end else begin
                        st_ff <= light_cmd_pkg::L_IGNORE;
                    end
                end
            endcase
        end
    end

    // sda is driven on the falling scl edge: acks and read data bits
    always_ff @(negedge SCL or negedge LINK_RESET_N) begin
        if (!LINK_RESET_N) begin
            SDA_OE <= 1'b0;
        end else begin
            SDA_OE <= (st_ff == light_cmd_pkg::L_ADDR_ACK) ||
                      (st_ff == light_cmd_pkg::L_WR_ACK) ||
                      ((st_ff == light_cmd_pkg::L_RD_BYTE) && !rd_sh_ff[15]);
        end
    end

    // open drain: the line is only ever pulled low
    always_ff @(negedge SCL or negedge LINK_RESET_N) begin
        if (!LINK_RESET_N) begin
            SDA_OUT <= 1'b0;
        end else begin
            SDA_OUT <= 1'b0;
        end
    end

    // ---------------- system domain ----------------
    logic                     stop_sync;     // synchronised stop toggle
    logic                     stop_seen_ff;  // last stop toggle acted on
    logic                     go_ff;         // one-cycle command strobe
    light_cmd_pkg::cmd_word_t cap_ff;        // command captured after a stop
    logic                     one_shot_ff;   // power down after this window
    logic [7:0]               applied_ff;    // setting used by the running window
    logic [16:0]              tick_ff;       // cycles within one setting unit
    logic [7:0]               unit_ff;       // setting units elapsed
    logic                     last_tick;     // final cycle of a unit
    logic                     done;          // window ends this cycle

    // a measurement start opcode of any resolution
    function automatic logic is_start(input logic [7:0] op);
        return (op == light_cmd_pkg::OP_CONT_H) || (op == light_cmd_pkg::OP_CONT_L) ||
               (op == light_cmd_pkg::OP_ONCE_H) || (op == light_cmd_pkg::OP_ONCE_L);
    endfunction

    // stop toggle into the system domain
    sync_two_ff #(.W(1)) u_stop_sync (
        .clk   (SYS_CLK),
        .rst_n (LINK_RESET_N),
        .d     (stop_tog_ff),
        .q     (stop_sync)
    );

    // after a stop the link engine is idle, so its opcode is steady to capture
    always_ff @(posedge SYS_CLK or negedge LINK_RESET_N) begin
        if (!LINK_RESET_N) begin
            stop_seen_ff <= 1'b0;
            go_ff        <= 1'b0;
            cap_ff       <= '0;
        end else if (RST) begin
            stop_seen_ff <= stop_sync;
            go_ff        <= 1'b0;
            cap_ff       <= '0;
        end else begin
            stop_seen_ff <= stop_sync;
            go_ff        <= (stop_sync != stop_seen_ff) && cmd_ff.pend;
            cap_ff       <= cmd_ff;
        end
    end

    // measurement time setting, written only through partial opcodes
    always_ff @(posedge SYS_CLK or negedge LINK_RESET_N) begin
        if (!LINK_RESET_N) begin
            MEAS_TIME <= light_cmd_pkg::TIME_SET_RESET;
        end else if (RST) begin
            MEAS_TIME <= light_cmd_pkg::TIME_SET_RESET;
        end else if (go_ff) begin
            if (cap_ff.op[7:3] == light_cmd_pkg::TIME_HI_PREFIX) begin
                MEAS_TIME[light_cmd_pkg::TIME_HI_MSB:light_cmd_pkg::TIME_HI_LSB]
                    <= cap_ff.op[2:0];
            end else if (cap_ff.op[7:5] == light_cmd_pkg::TIME_LO_PREFIX) begin
                MEAS_TIME[light_cmd_pkg::TIME_LO_MSB:light_cmd_pkg::TIME_LO_LSB]
                    <= cap_ff.op[4:0];
            end
        end
    end

    // window timing: setting units of a per-mode cycle count
    assign last_tick = HIGH_RES ? (tick_ff == 17'(H_UNIT - 1))
                                : (tick_ff == 17'(L_UNIT - 1));
    assign done      = MEASURING && last_tick && (unit_ff == applied_ff - 8'h01);

    // mode control: power state, resolution, repeat and applied setting
    always_ff @(posedge SYS_CLK or negedge LINK_RESET_N) begin
        if (!LINK_RESET_N) begin
            POWERED_ON  <= 1'b0;
            MEASURING   <= 1'b0;
            HIGH_RES    <= 1'b0;
            one_shot_ff <= 1'b0;
            applied_ff  <= light_cmd_pkg::TIME_SET_RESET;
        end else if (RST) begin
            POWERED_ON  <= 1'b0;
            MEASURING   <= 1'b0;
            HIGH_RES    <= 1'b0;
            one_shot_ff <= 1'b0;
            applied_ff  <= light_cmd_pkg::TIME_SET_RESET;
        end else if (go_ff && is_start(cap_ff.op)) begin
            // setting takes effect only here, for every resolution
            POWERED_ON  <= 1'b1;
            MEASURING   <= 1'b1;
            HIGH_RES    <= cap_ff.op[1:0] == 2'h0;
            one_shot_ff <= cap_ff.op[5];
            applied_ff  <= MEAS_TIME;
        end else if (go_ff && cap_ff.op == light_cmd_pkg::OP_POWER_ON) begin
            POWERED_ON <= 1'b1;
        end else if (go_ff && cap_ff.op == light_cmd_pkg::OP_POWER_DOWN) begin
            POWERED_ON <= 1'b0;
            MEASURING  <= 1'b0;
        end else if (done && one_shot_ff) begin
            POWERED_ON <= 1'b0;
            MEASURING  <= 1'b0;
        end
    end

    // counters restart with each start opcode; duration grows with setting
    always_ff @(posedge SYS_CLK or negedge LINK_RESET_N) begin
        if (!LINK_RESET_N) begin
            tick_ff <= 17'h00000;
            unit_ff <= 8'h00;
        end else if (RST || (go_ff && is_start(cap_ff.op)) || !MEASURING) begin
            tick_ff <= 17'h00000;
            unit_ff <= 8'h00;
        end else if (last_tick) begin
            tick_ff <= 17'h00000;
            unit_ff <= done ? 8'h00 : unit_ff + 8'h01;
        end else begin
            tick_ff <= tick_ff + 17'h00001;
        end
    end

    // result register: loaded at window end, cleared by the clear opcode while powered on
    always_ff @(posedge SYS_CLK or negedge LINK_RESET_N) begin
        if (!LINK_RESET_N) begin
            data_ff     <= 16'h0000;
            data_tog_ff <= 1'b0;
        end else if (RST) begin
            data_ff     <= 16'h0000;
            data_tog_ff <= ~data_tog_ff;
        end else if (done) begin
            data_ff     <= LIGHT_COUNT;
            data_tog_ff <= ~data_tog_ff;
        end else if (go_ff && POWERED_ON && cap_ff.op == light_cmd_pkg::OP_DATA_CLEAR) begin
            data_ff     <= 16'h0000;
            data_tog_ff <= ~data_tog_ff;
        end
    end
endmodule
`default_nettype wire

// ### bench/light_cmd_monitor.sv
// assertion checker for the light sensor command port, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module light_cmd_monitor (
    input wire logic       SYS_CLK,
    input wire logic       RST,
    input wire logic       LINK_RESET_N,
    input wire logic       SCL,
    input wire logic       SDA_IN,
    input wire logic       SDA_OUT,
    input wire logic       SDA_OE,
    input wire logic [7:0] MEAS_TIME,
    input wire logic       POWERED_ON,
    input wire logic       MEASURING,
    input wire logic       HIGH_RES
);
    logic       rst_q_ff;  // sync reset seen one edge ago
    logic       pin_low_ff; // reset pin seen low one edge ago
    logic [7:0] prev_ff;   // setting one edge ago
    logic [7:0] diff;      // setting bits that just changed

    // delayed copies, so a clear by reset is not taken for a bus write
    always_ff @(posedge SYS_CLK) begin
        rst_q_ff   <= RST;
        pin_low_ff <= ~LINK_RESET_N;
        prev_ff    <= MEAS_TIME;
    end
    assign diff = prev_ff ^ MEAS_TIME;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST || !LINK_RESET_N);

    // setting, power, measuring and resolution outputs at their power-up values
    sequence s_cleared;
        MEAS_TIME == light_cmd_pkg::TIME_SET_RESET && !POWERED_ON && !MEASURING && !HIGH_RES;
    endsequence
    // bus idle after a stop
    sequence s_bus_idle;
        SCL && SDA_IN;
    endsequence

    property p_sync_reset;
        disable iff (!LINK_RESET_N) RST |=> s_cleared;
    endproperty
    a_sync_reset: assert property (p_sync_reset) else $error("sync reset left state");
    property p_async_reset;
        disable iff (1'b0) !LINK_RESET_N && pin_low_ff |-> s_cleared;
    endproperty
    a_async_reset: assert property (p_async_reset) else $error("pin reset left state");
    property p_partial;
        (diff != 8'h00) && !rst_q_ff |-> diff[7:5] == 3'h0 || diff[4:0] == 5'h00;
    endproperty
    a_partial: assert property (p_partial) else $error("both setting fields moved");
    property p_commit_stop;
        (diff != 8'h00) && !rst_q_ff |-> s_bus_idle ##1 $stable(MEAS_TIME);
    endproperty
    a_commit_stop: assert property (p_commit_stop) else $error("setting moved in frame");
    property p_power_at_stop;
        $rose(POWERED_ON) |-> s_bus_idle;
    endproperty
    a_power_at_stop: assert property (p_power_at_stop) else $error("power-on in frame");
    property p_power_off_idle;
        $fell(POWERED_ON) |-> !MEASURING ##1 !MEASURING;
    endproperty
    a_power_off_idle: assert property (p_power_off_idle) else $error("measuring when off");
    property p_sda_stable;
        SCL && $past(SCL) |-> $stable(SDA_OE);
    endproperty
    a_sda_stable: assert property (p_sda_stable) else $error("data moved with clock high");
    property p_open_drain;
        SDA_OUT == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("data driven high");
endmodule

bind light_cmd_port light_cmd_monitor i_mon (
    .SYS_CLK(SYS_CLK), .RST(RST), .LINK_RESET_N(LINK_RESET_N), .SCL(SCL),
    .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .MEAS_TIME(MEAS_TIME),
    .POWERED_ON(POWERED_ON), .MEASURING(MEASURING), .HIGH_RES(HIGH_RES)
);
`default_nettype wire

// ### bench/bus_master_model.sv
// bus master model that drives the command port's serial link
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
    output logic      scl,      // bus clock, stands high between frames
    output logic      pull_low, // master pulls data low
    input  wire logic sda       // resolved data line
);
    localparam int Q = 20;      // quarter of the 80 ns bus clock
    // bus idle: clock high, data released to the pull-up
    initial begin
        scl = 1'b1;
        pull_low = 1'b0;
    end
    // start: data falls while the clock is high
    task automatic start_cond();
        pull_low = 1'b1;
        #Q;
        scl = 1'b0;
    endtask
    // one bit: data changes mid-low, sampled at the rising clock
    task automatic bit_xfer(input logic b, output logic r);
        #Q;
        pull_low = ~b;
        #Q;
        scl = 1'b1;
        r = sda;
        #(2*Q);
        scl = 1'b0;
    endtask
    // one byte msb first, then the acknowledge slot
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(b[i], r);
        end
        bit_xfer(1'b1, r);
        ack = ~r;
    endtask
    // one byte msb first, acknowledged unless it is the last
    task automatic recv_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, d[i]);
        end
        bit_xfer(last, r);
    endtask
    // stop closes every frame, then idle time for the commit
    task automatic stop_cond();
        #Q;
        pull_low = 1'b1;
        #Q;
        scl = 1'b1;
        #Q;
        pull_low = 1'b0;
        #200;
    endtask
endmodule
`default_nettype wire

// ### bench/tb.sv
// self-checking bench for the light sensor command port
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        sys_clk      = 1'b0;     // 40 MHz system clock
    logic        rst          = 1'b1;     // synchronous reset
    logic        link_reset_n = 1'b1;     // reset pin, pulled low just after power-up
    logic        addr_sel     = 1'b0;     // address select pin
    logic [15:0] light_count  = 16'h8390; // converter count
    logic        scl;                     // bus clock from the master
    logic        m_pull;                  // master pulls data low
    logic        sda_oe;                  // device pulls data low
    logic        sda_out;                 // device data level
    logic [7:0]  meas_time;               // measurement time setting
    logic        powered_on;              // power state
    logic        measuring;               // window running
    logic        high_res;                // high resolution mode
    logic        ack;                     // last acknowledge
    logic [15:0] word;                    // last word read
    logic [7:0]  op;                      // start opcode under test
    int          n;                       // window length seen
    int          e;                       // window length expected
    int          n_fail = 0;              // mismatches
    int          checks = 0;              // comparisons
    wire logic   sda = ~(m_pull | (sda_oe & ~sda_out)); // pull-up line

    always #12.5 sys_clk = ~sys_clk;

    // small unit counts keep windows short
    light_cmd_port #(.H_UNIT(4), .L_UNIT(2)) i_dut (
        .SYS_CLK(sys_clk), .RST(rst), .LINK_RESET_N(link_reset_n), .SCL(scl),
        .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .ADDR_SEL(addr_sel),
        .LIGHT_COUNT(light_count), .MEAS_TIME(meas_time), .POWERED_ON(powered_on),
        .MEASURING(measuring), .HIGH_RES(high_res)
    );
    bus_master_model i_master (.scl(scl), .pull_low(m_pull), .sda(sda));

    // compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // final report and end of run
    task automatic wrap_up();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // one opcode write frame; ack holds the last acknowledge
    task automatic wr(input logic [6:0] a, input logic [7:0] b);
        i_master.start_cond();
        i_master.send_byte({a, 1'b0}, ack);
        if (ack === 1'b1) begin
            i_master.send_byte(b, ack);
        end
        i_master.stop_cond();
        @(negedge sys_clk);
    endtask
    // two byte read into word
    task automatic rd(input logic [6:0] a);
        i_master.start_cond();
        i_master.send_byte({a, 1'b1}, ack);
        i_master.recv_byte(1'b0, word[15:8]);
        i_master.recv_byte(1'b1, word[7:0]);
        i_master.stop_cond();
        @(negedge sys_clk);
    endtask
    // count cycles until the window closes, bounded
    task automatic wait_meas();
        n = 0;
        while (measuring === 1'b1) begin
            @(negedge sys_clk);
            n++;
            if (n > 4000) begin
                n_fail++;
                wrap_up();
            end
        end
    endtask

    // hang guard
    initial begin
        repeat (100000) @(posedge sys_clk);
        n_fail++;
        wrap_up();
    end

    // main sequence
    initial begin
        // a real falling edge on the pin, so its asynchronous reset fires
        @(negedge sys_clk);
        link_reset_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        repeat (45) @(negedge sys_clk);
        check(meas_time, 8'h45);
        check(powered_on, 1'b0);
        link_reset_n = 1'b1;                       // low 47 cycles, over 1 us
        repeat (4) @(negedge sys_clk);
        // each select level: own address acks, the other is ignored
        for (int k = 0; k < 2; k++) begin
            addr_sel = k[0];
            wr(k[0] ? 7'h5c : 7'h23, 8'h01);
            check(ack, 1'b1);
            check(powered_on, 1'b1);
            wr(k[0] ? 7'h23 : 7'h5c, 8'h00);
            check(ack, 1'b0);
            check(powered_on, 1'b1);
        end
        // second opcode in one frame is refused, first still commits
        i_master.start_cond();
        i_master.send_byte({7'h5c, 1'b0}, ack);
        i_master.send_byte(8'h43, ack);
        check(ack, 1'b1);
        i_master.send_byte(8'h7f, ack);
        check(ack, 1'b0);
        i_master.stop_cond();
        @(negedge sys_clk);
        check(meas_time, 8'h65);
        // settings stay within 2d..fe throughout
        wr(7'h5c, 8'h44);
        check(meas_time, 8'h85);
        wr(7'h5c, 8'h6a);
        check(meas_time, 8'h8a);
        wr(7'h5c, 8'h20);                          // start after a change
        check(high_res, 1'b1);
        wait_meas();
        check((n > 540) && (n < 564), 1'b1);
        check(powered_on, 1'b0);
        rd(7'h5c);
        check(word, 16'h8390);
        // back to the power-up setting, then every start opcode
        wr(7'h5c, 8'h42);
        wr(7'h5c, 8'h65);
        check(meas_time, 8'h45);
        light_count = 16'h0110;
        for (int i = 0; i < 4; i++) begin
            op = {2'b00, i[1] ? 2'b10 : 2'b01, 2'b00, i[0] ? 2'b11 : 2'b00};
            wr(7'h5c, op);
            check(measuring, 1'b1);
            check(high_res, op[0] ? 1'b0 : 1'b1);
            if (op[5]) begin
                e = 69 * (op[0] ? 2 : 4);
                wait_meas();
                check((n > e - 12) && (n < e + 12), 1'b1);
                rd(7'h5c);
                check(word, 16'h0110);
            end else begin
                wr(7'h5c, 8'h00);
            end
        end
        // sync reset in mid-measurement restores the power-up state
        wr(7'h5c, 8'h44);
        check(meas_time, 8'h85);
        wr(7'h5c, 8'h10);
        rst = 1'b1;
        @(negedge sys_clk);
        rst = 1'b0;
        check(meas_time, 8'h45);
        check(measuring, 1'b0);
        @(negedge sys_clk);
        // reset pin in mid-measurement clears the setting
        wr(7'h5c, 8'h6a);
        check(meas_time, 8'h4a);
        wr(7'h5c, 8'h10);
        link_reset_n = 1'b0;
        repeat (48) @(negedge sys_clk);
        check(meas_time, 8'h45);
        check(measuring, 1'b0);
        link_reset_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        wrap_up();
    end
endmodule
`default_nettype wire
